// >>> core/rsx_regs.vh
// register map, field positions and codes of the receive exit controller
`ifndef RSX_REGS_VH
`define RSX_REGS_VH

// word indices (byte address is four times the index)
`define RSX_IDX_SEQ_CFG2 10'h037
`define RSX_IDX_CTRL 10'h040
`define RSX_IDX_STATE 10'h041
`define RSX_IDX_IRQ_STAT 10'h042
`define RSX_IDX_IRQ_MASK 10'h043

// sequencer_config_two fields
`define RSX_EXIT_MSB 7
`define RSX_EXIT_LSB 5
`define RSX_TMO_MSB 4
`define RSX_TMO_LSB 3
`define RSX_SEQ_CFG2_RST 8'h00

// control register fields
`define RSX_CTRL_LOW_POWER_BIT 0
`define RSX_CTRL_IDLE_SLEEP_BIT 1
`define RSX_CTRL_RST 2'h0

// receive exit selector codes
`define RSX_EXIT_PAYLOAD_DONE 3'h1
`define RSX_EXIT_PAYLOAD_LOWPWR 3'h2
`define RSX_EXIT_CHECKSUM 3'h3
`define RSX_EXIT_STRENGTH_OFF 3'h4
`define RSX_EXIT_SYNC_OFF 3'h5
`define RSX_EXIT_PREAMBLE_OFF 3'h6

// receive timeout selector codes
`define RSX_TMO_RESTART 2'h0
`define RSX_TMO_TRANSMIT 2'h1
`define RSX_TMO_LOWPWR 2'h2
`define RSX_TMO_OFF 2'h3

// interrupt status bits
`define RSX_IRQ_W 6
`define RSX_IRQ_PACKET 0
`define RSX_IRQ_HALT 1
`define RSX_IRQ_IDLE 2
`define RSX_IRQ_TX 3
`define RSX_IRQ_RESTART 4
`define RSX_IRQ_TIMEOUT 5
`define RSX_IRQ_RST 6'h00

// axi response codes
`define RSX_RESP_OKAY 2'h0
`define RSX_RESP_SLVERR 2'h2

`endif

// >>> core/rsx_rst_sync.v
// two-stage release synchroniser for the asynchronous reset
`timescale 1ns/1ps
module rsx_rst_sync
(
	input wire clock,
	input wire resetn,
	output wire rst_sync_n
);
	reg meta_ff;
	reg hold_ff;

	// assert at once, release after two clock edges
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= 1'b0;
			hold_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= 1'b1;
			hold_ff <= meta_ff;
		end
	end

	assign rst_sync_n = hold_ff;
endmodule

// >>> core/rsx_exit_ctrl.v
// receive state exit controller of the radio sequencer with axi4-lite slave
// Operation
// - exit code 001: payload complete moves receive to packet done
// - exit code 010: payload complete moves receive to low power choice
// - exit code 011: checksum good moves receive to packet done
// - codes 100/101/110: strength, sync, preamble event halts the sequencer
// - timeout code picks restart, transmit, low power choice or halt
// - code 011: payload without good checksum follows the timeout choice
// - receive timeout is any of strength, preamble or sync timeouts
// - low power choice: 0 halts in initial mode, 1 enters idle
`timescale 1ns/1ps
`include "rsx_regs.vh"
module rsx_exit_ctrl
(
	input wire clock,
	input wire resetn,
	input wire clock_enable,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	output wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	input wire enter_receive,
	input wire sequencer_stop,
	input wire payload_complete_event,
	input wire checksum_good_event,
	input wire signal_strength_event,
	input wire sync_match_event,
	input wire preamble_found_event,
	input wire signal_strength_timeout,
	input wire preamble_timeout,
	input wire sync_signal_timeout,
	output wire [2:0] sequencer_state,
	output wire reception_restart,
	output wire idle_sleep_mode,
	output wire receive_timeout_event,
	output wire irq
);
	// sequencer states
	localparam ST_HALTED = 3'h0;
	localparam ST_RECEIVE = 3'h1;
	localparam ST_PACKET_DONE = 3'h2;
	localparam ST_TRANSMIT = 3'h3;
	localparam ST_IDLE = 3'h4;

	wire rst_n, ce;
	reg [2:0] exit_sel_ff;
	reg [1:0] tmo_sel_ff;
	reg [1:0] ctrl_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg restart_ff, nxt_restart;
	reg [5:0] prev_ff;
	reg [`RSX_IRQ_W-1:0] irq_stat_ff;
	reg [`RSX_IRQ_W-1:0] irq_mask_ff;
	reg [`RSX_IRQ_W-1:0] evt_set;
	reg aw_got_ff, w_got_ff;
	reg [9:0] aw_idx_ff;
	reg [31:0] wdata_ff;
	reg wstrb0_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff, rresp_ff;
	reg rvalid_ff;
	reg [31:0] rdata_ff;
	reg [31:0] rd_word;
	reg rd_ok;
	wire [5:0] evt_level, evt_rise;
	wire tmo_any;
	wire wr_fire, wr_ok;
	wire [2:0] low_power_dest;
	wire [7:0] cfg2_word;

	assign ce = clock_enable;

	rsx_rst_sync u_rst_sync
	(
		.clock(clock),
		.resetn(resetn),
		.rst_sync_n(rst_n)
	);

	// receive timeout is the or of the three timeouts
	assign tmo_any = signal_strength_timeout | preamble_timeout |
		sync_signal_timeout;
	assign receive_timeout_event = tmo_any;

	// rising edges so that a held level gives only one transition
	assign evt_level = {tmo_any, preamble_found_event, sync_match_event,
		signal_strength_event, checksum_good_event, payload_complete_event};
	assign evt_rise = evt_level & ~prev_ff;

	// low power choice destination
	assign low_power_dest = ctrl_ff[`RSX_CTRL_LOW_POWER_BIT] ?
		ST_IDLE : ST_HALTED;
	assign idle_sleep_mode = ctrl_ff[`RSX_CTRL_IDLE_SLEEP_BIT];

	// next state of the sequencer; exit events win over timeouts
	always @*
	begin
		nxt_state = state_ff;
		nxt_restart = 1'b0;
		if (sequencer_stop)
			nxt_state = ST_HALTED;
		else if (state_ff != ST_RECEIVE)
		begin
			if (enter_receive)
				nxt_state = ST_RECEIVE;
		end
		else
		begin
			// only the receive state evaluates exits
			case (exit_sel_ff)
			`RSX_EXIT_PAYLOAD_DONE:
				if (evt_rise[0])
					nxt_state = ST_PACKET_DONE;
			`RSX_EXIT_PAYLOAD_LOWPWR:
				if (evt_rise[0])
					nxt_state = low_power_dest;
			`RSX_EXIT_CHECKSUM:
				if (evt_rise[1])
					nxt_state = ST_PACKET_DONE;
			`RSX_EXIT_STRENGTH_OFF:
				if (evt_rise[2])
					nxt_state = ST_HALTED;
			`RSX_EXIT_SYNC_OFF:
				if (evt_rise[3])
					nxt_state = ST_HALTED;
			`RSX_EXIT_PREAMBLE_OFF:
				if (evt_rise[4])
					nxt_state = ST_HALTED;
			default: // unused codes take no event exit
				nxt_state = state_ff;
			endcase
			// timeout, or payload without good checksum under code 011
			if ((nxt_state == ST_RECEIVE) && (evt_rise[5] ||
				((exit_sel_ff == `RSX_EXIT_CHECKSUM) && evt_rise[0] &&
				!checksum_good_event)))
			begin
				case (tmo_sel_ff)
				`RSX_TMO_RESTART:
					nxt_restart = 1'b1;
				`RSX_TMO_TRANSMIT:
					nxt_state = ST_TRANSMIT;
				`RSX_TMO_LOWPWR:
					nxt_state = low_power_dest;
				`RSX_TMO_OFF:
					nxt_state = ST_HALTED;
				default:
					nxt_state = state_ff;
				endcase
			end
		end
	end

	// state, restart pulse and edge history
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_HALTED;
			restart_ff <= 1'b0;
			prev_ff <= 6'h00;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			restart_ff <= nxt_restart;
			prev_ff <= evt_level;
		end
	end

	assign sequencer_state = state_ff;
	assign reception_restart = restart_ff;

	// interrupt sources: entry into each destination, reception restart and receive timeout
	always @*
	begin
		evt_set = `RSX_IRQ_RST;
		if (nxt_state != state_ff)
		begin
			evt_set[`RSX_IRQ_PACKET] = (nxt_state == ST_PACKET_DONE);
			evt_set[`RSX_IRQ_HALT] = (nxt_state == ST_HALTED);
			evt_set[`RSX_IRQ_IDLE] = (nxt_state == ST_IDLE);
			evt_set[`RSX_IRQ_TX] = (nxt_state == ST_TRANSMIT);
		end
		evt_set[`RSX_IRQ_RESTART] = nxt_restart;
		evt_set[`RSX_IRQ_TIMEOUT] = evt_rise[5] && (state_ff == ST_RECEIVE);
	end

	// axi write side: address and data taken in either order
	assign s_axi_awready = ce & ~aw_got_ff & ~bvalid_ff;
	assign s_axi_wready = ce & ~w_got_ff & ~bvalid_ff;
	assign wr_fire = ce & aw_got_ff & w_got_ff & ~bvalid_ff;
	assign wr_ok = (aw_idx_ff == `RSX_IDX_SEQ_CFG2) ||
		(aw_idx_ff == `RSX_IDX_CTRL) || (aw_idx_ff == `RSX_IDX_STATE) ||
		(aw_idx_ff == `RSX_IDX_IRQ_STAT) || (aw_idx_ff == `RSX_IDX_IRQ_MASK);

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_idx_ff <= 10'h000;
			wdata_ff <= 32'h00000000;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RSX_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_ff <= 1'b1;
				aw_idx_ff <= s_axi_awaddr[11:2];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb0_ff <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? `RSX_RESP_OKAY : `RSX_RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// writable registers; hardware set wins over write-one-to-clear
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			exit_sel_ff <= 3'h0;
			tmo_sel_ff <= 2'h0;
			ctrl_ff <= `RSX_CTRL_RST;
			irq_stat_ff <= `RSX_IRQ_RST;
			irq_mask_ff <= `RSX_IRQ_RST;
		end
		else if (ce)
		begin
			if (wr_fire && wstrb0_ff &&
				(aw_idx_ff == `RSX_IDX_SEQ_CFG2))
			begin
				exit_sel_ff <= wdata_ff[`RSX_EXIT_MSB:`RSX_EXIT_LSB];
				tmo_sel_ff <= wdata_ff[`RSX_TMO_MSB:`RSX_TMO_LSB];
			end
			if (wr_fire && wstrb0_ff && (aw_idx_ff == `RSX_IDX_CTRL))
				ctrl_ff <= wdata_ff[1:0];
			if (wr_fire && wstrb0_ff && (aw_idx_ff == `RSX_IDX_IRQ_MASK))
				irq_mask_ff <= wdata_ff[`RSX_IRQ_W-1:0];
			if (wr_fire && wstrb0_ff && (aw_idx_ff == `RSX_IDX_IRQ_STAT))
				irq_stat_ff <= (irq_stat_ff & ~wdata_ff[`RSX_IRQ_W-1:0]) |
					evt_set;
			else
				irq_stat_ff <= irq_stat_ff | evt_set;
		end
	end

	// level interrupt while any unmasked status bit is set
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// read data mux
	assign cfg2_word = {exit_sel_ff, tmo_sel_ff, 3'h0};
	always @*
	begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr[11:2])
		`RSX_IDX_SEQ_CFG2:
			rd_word[7:0] = cfg2_word;
		`RSX_IDX_CTRL:
			rd_word[1:0] = ctrl_ff;
		`RSX_IDX_STATE:
			rd_word[2:0] = state_ff;
		`RSX_IDX_IRQ_STAT:
			rd_word[`RSX_IRQ_W-1:0] = irq_stat_ff;
		`RSX_IDX_IRQ_MASK:
			rd_word[`RSX_IRQ_W-1:0] = irq_mask_ff;
		default:
			rd_ok = 1'b0;
		endcase
	end

	// axi read side: one cycle from address to data
	assign s_axi_arready = ce & ~rvalid_ff;
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `RSX_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_word;
				rresp_ff <= rd_ok ? `RSX_RESP_OKAY : `RSX_RESP_SLVERR;
			end
			else if (rvalid_ff && s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule

// >>> testbench/rsx_exit_ctrl_monitor.sv
// assertion checker bound to the receive exit controller ports
`timescale 1ns/1ps
module rsx_exit_ctrl_monitor
(
	input wire clock,
	input wire resetn,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire enter_receive,
	input wire sequencer_stop,
	input wire payload_complete_event,
	input wire checksum_good_event,
	input wire signal_strength_timeout,
	input wire preamble_timeout,
	input wire sync_signal_timeout,
	input wire [2:0] sequencer_state,
	input wire reception_restart,
	input wire receive_timeout_event
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// timeout condition and sequencer transitions
	a_timeout_any: assert property (receive_timeout_event ==
		(signal_strength_timeout | preamble_timeout | sync_signal_timeout))
		else $error("timeout condition wrong");
	a_no_exit_outside: assert property (sequencer_state != 3'h1 &&
		!enter_receive && !sequencer_stop |=> $stable(sequencer_state))
		else $error("state moved outside receive");
	a_packet_cause: assert property (sequencer_state == 3'h1 ##1
		sequencer_state == 3'h2 |-> $past(payload_complete_event |
		checksum_good_event)) else $error("packet done without event");
	a_restart_pulse: assert property (reception_restart |->
		sequencer_state == 3'h1 ##1 !reception_restart)
		else $error("restart pulse wrong");
	// code 011 also restarts on a payload without a good checksum
	a_restart_cause: assert property (reception_restart |->
		$past(receive_timeout_event | payload_complete_event))
		else $error("restart without cause");
	a_stop_halts: assert property (sequencer_stop |=>
		sequencer_state == 3'h0) else $error("stop did not halt");

	// register bus answers
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("write response held");

	// main scenarios reached
	c_packet: cover property (sequencer_state == 3'h2);
	c_transmit: cover property (sequencer_state == 3'h3);
	c_restart: cover property (reception_restart);
endmodule

bind rsx_exit_ctrl rsx_exit_ctrl_monitor u_mon (.*);

// >>> testbench/rsx_exit_ctrl_tb_top.sv
// self-checking bench of the receive exit controller
`timescale 1ns/1ps
`include "rsx_regs.vh"
module rsx_exit_ctrl_tb_top;
	logic clock, resetn, clock_enable, enter_receive, sequencer_stop;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, seed, rd, wv;
	logic [3:0] s_axi_wstrb;
	logic [7:0] stim;
	logic [4:0] ev;
	logic [1:0] rr;
	logic lp, rst_seen, tmo_seen;
	wire payload_complete_event, checksum_good_event, signal_strength_event;
	wire sync_match_event, preamble_found_event, signal_strength_timeout;
	wire preamble_timeout, sync_signal_timeout;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, reception_restart, idle_sleep_mode;
	wire receive_timeout_event, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0] sequencer_state;
	int n_mismatch, total_checks;

	// events in the upper five bits, timeouts in the lower three
	assign {payload_complete_event, checksum_good_event, signal_strength_event,
		sync_match_event, preamble_found_event, signal_strength_timeout,
		preamble_timeout, sync_signal_timeout} = stim;

	rsx_exit_ctrl u_dut (.*);

	// free running clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// next value of the xorshift sequence
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// state after the trigger of an exit code
	function automatic logic [2:0] exp_exit(input logic [2:0] c, input logic l);
		case (c)
			3'h1, 3'h3: return 3'h2;
			3'h2: return l ? 3'h4 : 3'h0;
			default: return 3'h0;
		endcase
	endfunction

	// state after a timeout choice
	function automatic logic [2:0] exp_tmo(input logic [1:0] t, input logic l);
		case (t)
			2'h0: return 3'h1;
			2'h1: return 3'h3;
			2'h2: return l ? 3'h4 : 3'h0;
			default: return 3'h0;
		endcase
	endfunction

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one register write, response code left in rr
	task automatic axi_wr(input logic [9:0] i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (!s_axi_bvalid && n < 50);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50)
		begin
			n_mismatch++;
			$display("unexpected at %0t: write answer missing", $time);
		end
	endtask

	// one register read into rd and rr
	task automatic axi_rd(input logic [9:0] i);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (!s_axi_rvalid && n < 50);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50)
		begin
			n_mismatch++;
			$display("unexpected at %0t: read answer missing", $time);
		end
	endtask

	// halt, then enter receive
	task automatic go_rx;
		sequencer_stop <= 1'b1;
		@(posedge clock);
		sequencer_stop <= 1'b0;
		enter_receive <= 1'b1;
		@(posedge clock);
		enter_receive <= 1'b0;
		@(posedge clock);
		chk(sequencer_state, 3'h1);
	endtask

	// one-cycle pulse on events and timeouts
	task automatic pulse(input logic [7:0] v);
		stim <= v;
		@(negedge clock);
		tmo_seen = receive_timeout_event;
		@(posedge clock);
		stim <= 8'h00;
		@(negedge clock);
		rst_seen = reception_restart;
		@(posedge clock);
	endtask

	// verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial
	begin
		#200000;
		n_mismatch++;
		report_and_stop;
	end

	// main sequence
	initial
	begin
		{resetn, enter_receive, sequencer_stop, stim} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
		{s_axi_awprot, s_axi_arprot, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hF;
		clock_enable = 1'b1;
		seed = 32'h7842;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		axi_rd(`RSX_IDX_SEQ_CFG2);
		chk(rd, 32'h0);
		axi_rd(10'h3FF);
		chk(rr, `RSX_RESP_SLVERR);
		chk(rd, 32'h0);
		repeat (4)
		begin
			seed = xs(seed);
			wv = seed;
			// keep the exit field off the two unused codes
			if (wv[7:5] == 3'h0 || wv[7:5] == 3'h7)
				wv[7:5] = 3'h3;
			axi_wr(`RSX_IDX_SEQ_CFG2, wv);
			chk(rr, `RSX_RESP_OKAY);
			axi_rd(`RSX_IDX_SEQ_CFG2);
			chk(rd, wv & 32'hF8);
		end
		for (int c = 1; c < 7; c++)
		begin
			seed = xs(seed);
			lp = seed[0];
			ev = c < 3 ? 5'h10 : 5'h10 >> (c - 2);
			rd = {29'h0, exp_exit(c[2:0], lp)};
			axi_wr(`RSX_IDX_CTRL, {30'h0, seed[1], lp});
			chk(idle_sleep_mode, seed[1]);
			axi_wr(`RSX_IDX_SEQ_CFG2, {24'h0, c[2:0], 5'h00});
			go_rx;
			pulse({c > 3 ? 5'h10 : 5'h04, 3'h0});
			chk(sequencer_state, 3'h1);
			pulse({ev, 3'h0});
			chk(sequencer_state, rd);
			pulse({ev, 3'h0});
			chk(sequencer_state, rd);
		end
		for (int t = 0; t < 4; t++)
		begin
			seed = xs(seed);
			lp = seed[0];
			axi_wr(`RSX_IDX_CTRL, {31'h0, lp});
			// exit only on strength or preamble, never an unused code
			axi_wr(`RSX_IDX_SEQ_CFG2,
				{24'h0, seed[2] ? 3'h4 : 3'h6, t[1:0], 3'h0});
			go_rx;
			pulse(8'hD0);
			chk(sequencer_state, 3'h1);
			pulse({5'h00, 3'h1 << (seed[9:8] % 3)});
			chk(tmo_seen, 1'b1);
			chk(rst_seen, t == 0);
			chk(sequencer_state, exp_tmo(t[1:0], lp));
			axi_wr(`RSX_IDX_SEQ_CFG2, {24'h0, 3'h3, t[1:0], 3'h0});
			go_rx;
			pulse(8'h80);
			chk(sequencer_state, exp_tmo(t[1:0], lp));
			chk(rst_seen, t == 0);
		end
		axi_wr(`RSX_IDX_SEQ_CFG2, 32'h20);
		go_rx;
		axi_wr(`RSX_IDX_IRQ_STAT, 32'h3F);
		axi_wr(`RSX_IDX_IRQ_MASK, 32'h0);
		// a frozen clock enable must swallow the event
		clock_enable <= 1'b0;
		pulse(8'h80);
		chk(sequencer_state, 3'h1);
		clock_enable <= 1'b1;
		pulse(8'h80);
		axi_rd(`RSX_IDX_IRQ_STAT);
		chk(rd, 32'h1);
		// a mask bit of one lets its status bit through
		chk(irq, 1'b0);
		axi_wr(`RSX_IDX_IRQ_MASK, 32'h3F);
		chk(irq, 1'b1);
		axi_wr(`RSX_IDX_IRQ_STAT, 32'h1);
		chk(irq, 1'b0);
		report_and_stop;
	end
endmodule
